// [src/touch_report_i2c_slave.sv]
module touch_report_i2c_slave
(
   // system clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   // link oversampling clock
   input  wire logic       link_clk_in,
   // serial bus pins
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_out,
   // live report updates from the touch engine
   input  wire logic       live_wr_in,
   input  wire logic [4:0] live_addr_in,
   input  wire logic [7:0] live_data_in,
   input  wire logic       live_event_in,
   // status
   output logic            int_n_out,
   output logic            read_protect_out,
   output logic            refresh_pending_out
);

   // ==========================================================
   // link domain: pin sampling
   typedef enum logic [6:0]
   {
      ST_IDLE     = 7'b000_0001,
      ST_ADDR     = 7'b000_0010,
      ST_ACK_ADDR = 7'b000_0100,
      ST_WR       = 7'b000_1000,
      ST_ACK_WR   = 7'b001_0000,
      ST_RD       = 7'b010_0000,
      ST_RD_ACK   = 7'b100_0000
   } link_state_t;

   logic        link_rst;
   logic        scl_s;
   logic        sda_s;
   logic        scl_p_q;
   logic        sda_p_q;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_det;
   logic        stop_det;

   sync_ff u_rst_sync
   (
      .clk_in (link_clk_in),
      .d_in   (rst_in),
      .q_out  (link_rst)
   );

   // oversampling far above 400 khz keeps both bus speeds
   sync_ff u_scl_sync
   (
      .clk_in (link_clk_in),
      .d_in   (scl_in),
      .q_out  (scl_s)
   ); // [RL18]

   sync_ff u_sda_sync
   (
      .clk_in (link_clk_in),
      .d_in   (sda_in),
      .q_out  (sda_s)
   );

   always_ff @(posedge link_clk_in)
   begin
      if (link_rst)
      begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end
      else
      begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   assign scl_rise  = scl_s & ~scl_p_q;
   assign scl_fall  = ~scl_s & scl_p_q;
   assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;

   // ==========================================================
   // link domain: byte engine
   link_state_t st_q;
   logic [2:0]  cnt_q;
   logic [7:0]  shift_q;
   logic        oe_q;
   logic        rw_q;
   logic        first_q;
   logic        acked_q;
   logic [7:0]  ptr_q;
   logic        protect_q;
   logic        req_tgl_q;
   logic        req_wr_q;
   logic [7:0]  req_addr_q;
   logic [7:0]  req_data_q;
   logic [7:0]  rd_hold_q;
   logic        ack_tgl_q;
   logic [7:0]  rd_data_q;
   logic        ack_s;
   logic        ack_p_q;
   logic [7:0]  rx_byte;
   logic        byte_done;
   logic        addr_hit;
   logic        wr_done;
   logic        rd_last;

   assign rx_byte   = {shift_q[6:0], sda_s};
   assign byte_done = scl_rise & (cnt_q == 3'h7);
   assign addr_hit  = (st_q == ST_ADDR) & byte_done &
                      (rx_byte[7:1] == touch_report_pkg::DEV_ADDR); // [RL16]
   assign wr_done   = (st_q == ST_WR) & byte_done;
   assign rd_last   = (st_q == ST_RD) & scl_fall & (cnt_q == 3'h7);

   always_ff @(posedge link_clk_in)
   begin
      if (link_rst)
      begin
         st_q    <= ST_IDLE;
         cnt_q   <= 3'h0;
         shift_q <= 8'h00;
         oe_q    <= 1'b0;
         rw_q    <= 1'b0;
         first_q <= 1'b1;
         acked_q <= 1'b0;
      end
      else if (start_det)
      begin
         st_q    <= ST_ADDR;
         cnt_q   <= 3'h0;
         oe_q    <= 1'b0;
         first_q <= 1'b1; // [RL9]
      end
      else if (stop_det)
      begin
         st_q <= ST_IDLE; // [RL8]
         oe_q <= 1'b0;
      end
      else
      begin
         case (st_q)
            ST_IDLE:
            begin
               oe_q <= 1'b0;
            end
            ST_ADDR:
            begin
               if (scl_rise)
               begin
                  shift_q <= rx_byte;
                  cnt_q   <= cnt_q + 3'h1;
                  if (cnt_q == 3'h7)
                  begin
                     rw_q <= rx_byte[0];
                     st_q <= addr_hit ? ST_ACK_ADDR : ST_IDLE;
                  end
               end
            end
            ST_ACK_ADDR, ST_ACK_WR:
            begin
               if (scl_fall)
               begin
                  if (!oe_q)
                     oe_q <= 1'b1;
                  else if (rw_q && st_q == ST_ACK_ADDR)
                  begin
                     st_q    <= ST_RD;
                     cnt_q   <= 3'h0;
                     shift_q <= rd_hold_q;
                     oe_q    <= ~rd_hold_q[7];
                  end
                  else
                  begin
                     st_q  <= ST_WR;
                     cnt_q <= 3'h0;
                     oe_q  <= 1'b0;
                  end
               end
            end
            ST_WR:
            begin
               if (scl_rise)
               begin
                  shift_q <= rx_byte;
                  cnt_q   <= cnt_q + 3'h1;
                  if (cnt_q == 3'h7)
                  begin
                     st_q    <= ST_ACK_WR;
                     first_q <= 1'b0;
                  end
               end
            end
            ST_RD:
            begin
               if (scl_fall)
               begin
                  if (cnt_q == 3'h7)
                  begin
                     oe_q <= 1'b0;
                     st_q <= ST_RD_ACK;
                  end
                  else
                  begin
                     cnt_q   <= cnt_q + 3'h1;
                     shift_q <= {shift_q[6:0], 1'b0};
                     oe_q    <= ~shift_q[6];
                  end
               end
            end
            ST_RD_ACK:
            begin
               if (scl_rise)
                  acked_q <= ~sda_s;
               if (scl_fall)
               begin
                  // controller ack keeps the sequential read going
                  if (acked_q)
                  begin
                     st_q    <= ST_RD; // [RL1]
                     cnt_q   <= 3'h0;
                     shift_q <= rd_hold_q;
                     oe_q    <= ~rd_hold_q[7];
                  end
                  else
                     st_q <= ST_IDLE;
               end
            end
            default:
            begin
               st_q <= ST_IDLE;
               oe_q <= 1'b0;
            end
         endcase
      end
   end

   // pointer survives stops; only a write sets it
   always_ff @(posedge link_clk_in)
   begin
      if (link_rst)
         ptr_q <= touch_report_pkg::PTR_RST; // [RL19]
      else if (wr_done && first_q)
         ptr_q <= rx_byte; // [RL9] [RL2]
      else if (wr_done || rd_last)
         ptr_q <= ptr_q + 8'h01; // [RL11]
   end

   // protection spans the whole read, even past repeated starts
   always_ff @(posedge link_clk_in)
   begin
      if (link_rst)
         protect_q <= 1'b0;
      else if (stop_det)
         protect_q <= 1'b0; // [RL6]
      else if (addr_hit && rx_byte[0])
         protect_q <= 1'b1; // [RL5]
   end

   // request fields hold still until the next toggle
   always_ff @(posedge link_clk_in)
   begin
      if (link_rst)
      begin
         req_tgl_q  <= 1'b0;
         req_wr_q   <= 1'b0;
         req_addr_q <= 8'h00;
         req_data_q <= 8'h00;
      end
      else if (addr_hit && rx_byte[0])
      begin
         req_tgl_q  <= ~req_tgl_q;
         req_wr_q   <= 1'b0;
         req_addr_q <= ptr_q; // [RL2]
      end
      else if (rd_last)
      begin
         // prefetch during the ack bit to meet fast mode timing
         req_tgl_q  <= ~req_tgl_q;
         req_wr_q   <= 1'b0;
         req_addr_q <= ptr_q + 8'h01;
      end
      else if (wr_done && !first_q)
      begin
         req_tgl_q  <= ~req_tgl_q; // [RL10]
         req_wr_q   <= 1'b1;
         req_addr_q <= ptr_q;
         req_data_q <= rx_byte;
      end
   end

   sync_ff u_ack_sync
   (
      .clk_in (link_clk_in),
      .d_in   (ack_tgl_q),
      .q_out  (ack_s)
   );

   always_ff @(posedge link_clk_in)
   begin
      if (link_rst)
      begin
         ack_p_q   <= 1'b0;
         rd_hold_q <= 8'h00;
      end
      else
      begin
         ack_p_q <= ack_s;
         if (ack_s != ack_p_q)
            rd_hold_q <= rd_data_q;
      end
   end

   assign sda_out    = 1'b0;
   assign sda_oe_out = oe_q;

   // ==========================================================
   // system domain: request service
   logic        req_s;
   logic        req_p_q;
   logic        req_ev;
   logic        protect_s;
   logic [7:0]  int_width_q;
   logic        pending_q;
   logic        refresh;
   logic [7:0]  live_mem [touch_report_pkg::REPORT_BYTES];
   logic [7:0]  snap_mem [touch_report_pkg::REPORT_BYTES];

   sync_ff u_req_sync
   (
      .clk_in (clk_in),
      .d_in   (req_tgl_q),
      .q_out  (req_s)
   );

   sync_ff u_prot_sync
   (
      .clk_in (clk_in),
      .d_in   (protect_q),
      .q_out  (protect_s)
   );

   assign req_ev = req_s ^ req_p_q;

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         req_p_q <= 1'b0;
      else
         req_p_q <= req_s;
   end

   // reads answer from the snapshot, never from live data
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         rd_data_q <= 8'h00;
         ack_tgl_q <= 1'b0;
      end
      else if (req_ev && !req_wr_q)
      begin
         ack_tgl_q <= ~ack_tgl_q;
         if (req_addr_q <= touch_report_pkg::REPORT_LAST_OFF)
            rd_data_q <= snap_mem[req_addr_q[4:0]]; // [RL3] [RL4] [RL12]
         else
            rd_data_q <= 8'h00; // [RL19]
      end
   end

   // report bytes are read only; writes there are dropped
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         int_width_q <= touch_report_pkg::INT_WIDTH_RST;
      else if (req_ev && req_wr_q &&
               req_addr_q == touch_report_pkg::INT_WIDTH_OFF)
         int_width_q <= req_data_q; // [RL15] [RL10]
   end

   // ==========================================================
   // system domain: snapshot
   assign refresh = pending_q & ~protect_s; // [RL5] [RL6]

   // a new event in the refresh cycle keeps the request pending
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         pending_q <= 1'b0;
      else if (live_event_in)
         pending_q <= 1'b1;
      else if (refresh)
         pending_q <= 1'b0;
   end

   for (genvar i = 0; i < touch_report_pkg::REPORT_BYTES; i++)
   begin : g_report
      always_ff @(posedge clk_in)
      begin
         if (rst_in)
            live_mem[i] <= touch_report_pkg::REPORT_RST;
         else if (live_wr_in && live_addr_in == 5'(i))
            live_mem[i] <= live_data_in;
      end

      always_ff @(posedge clk_in)
      begin
         if (rst_in)
            snap_mem[i] <= touch_report_pkg::REPORT_RST;
         else if (refresh)
            snap_mem[i] <= live_mem[i]; // [RL3] [RL14]
      end
   end

   int_pulse_gen u_int
   (
      .clk_in    (clk_in),
      .rst_in    (rst_in),
      .start_in  (refresh),
      .width_in  (int_width_q),
      .int_n_out (int_n_out)
   ); // [RL17]

   assign read_protect_out    = protect_s;
   assign refresh_pending_out = pending_q;

endmodule

// [src/touch_report_pkg.sv]
// Behaviour
// [RL1] host picks read length; single and sequential reads both work
// [RL2] host writes the start address before a read; read starts there
// [RL3] bus reads come from a snapshot copy, live data keeps updating
// [RL4] read from zero gives touch state, buttons, then fingers one to five
// [RL5] new touch event during an open read delays the snapshot refresh
// [RL6] stop condition lifts snapshot protection so refresh may proceed
// [RL7] host should read all fingers in one transfer without stops
// [RL8] write length is host chosen; a stop ends the write
// [RL9] first byte after the device address is the register pointer
// [RL10] each written data byte is stored as soon as it arrives
// [RL11] pointer increments after every data byte, read or write
// [RL12] 0 touch state, 1 buttons, 2-3 finger one x, 4-5 finger one y
// [RL13] finger record is five bytes: x, y, tag; tag one at 6
// [RL14] five finger records, finger five tag at 26 is last
// [RL15] interrupt pulse width is set by a host write
// [RL16] answer only to seven bit bus address 0x5c
// [RL17] interrupt output goes low to announce new touch data
// [RL18] bus runs at 100 khz and 400 khz
// [RL19] reads past 26 give zero; pointer kept between transfers
package touch_report_pkg;

   // ==========================================================
   // bus identity
   localparam logic [6:0] DEV_ADDR         = 7'h5C; // [RL16]

   // ==========================================================
   // report map (byte offsets)
   localparam logic [7:0] TOUCH_STATE_OFF  = 8'h00; // [RL12]
   localparam logic [7:0] BUTTON_STATE_OFF = 8'h01;
   localparam logic [7:0] FINGER1_X_OFF    = 8'h02;
   localparam logic [7:0] FINGER1_Y_OFF    = 8'h04;
   localparam logic [7:0] FINGER1_TAG_OFF  = 8'h06; // [RL13]
   localparam logic [7:0] FINGER2_X_OFF    = 8'h07;
   localparam logic [7:0] FINGER2_Y_OFF    = 8'h09;
   localparam logic [7:0] FINGER2_TAG_OFF  = 8'h0B;
   localparam logic [7:0] FINGER3_X_OFF    = 8'h0C;
   localparam logic [7:0] FINGER3_Y_OFF    = 8'h0E;
   localparam logic [7:0] FINGER3_TAG_OFF  = 8'h10;
   localparam logic [7:0] FINGER4_X_OFF    = 8'h11;
   localparam logic [7:0] FINGER4_Y_OFF    = 8'h13;
   localparam logic [7:0] FINGER4_TAG_OFF  = 8'h15;
   localparam logic [7:0] FINGER5_X_OFF    = 8'h16;
   localparam logic [7:0] FINGER5_Y_OFF    = 8'h18;
   localparam logic [7:0] FINGER5_TAG_OFF  = 8'h1A;
   localparam logic [7:0] REPORT_LAST_OFF  = 8'h1A; // [RL14]
   localparam int         REPORT_BYTES     = 27;

   // ==========================================================
   // setting register and reset values
   localparam logic [7:0] INT_WIDTH_OFF    = 8'h1B; // [RL15]
   localparam logic [7:0] INT_WIDTH_RST    = 8'h0A;
   localparam logic [7:0] PTR_RST          = 8'h00;
   localparam logic [7:0] REPORT_RST       = 8'h00;

   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int INT_UNIT_NS   = 1000;
   localparam int INT_UNIT_CYC  =
      (INT_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// [src/sync_ff.sv]
module sync_ff
(
   // clock
   input  wire logic clk_in,
   // async level
   input  wire logic d_in,
   // synchronised level
   output logic      q_out
);

   logic meta_q;

   // meta_q feeds only the second stage
   always_ff @(posedge clk_in)
   begin
      meta_q <= d_in;
      q_out  <= meta_q;
   end

endmodule

// [src/int_pulse_gen.sv]
module int_pulse_gen
(
   // clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   // trigger and width in units
   input  wire logic       start_in,
   input  wire logic [7:0] width_in,
   // active low interrupt
   output logic            int_n_out
);

   logic [11:0] cnt_q;
   logic [11:0] load;

   // width zero behaves as one unit so no event is lost
   always_comb
   begin
      if (width_in == 8'h00)
         load = 12'(touch_report_pkg::INT_UNIT_CYC);
      else
         load = 12'(32'(width_in) * touch_report_pkg::INT_UNIT_CYC);
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         cnt_q <= 12'h000;
      else if (start_in)
         cnt_q <= load; // [RL15]
      else if (cnt_q != 12'h000)
         cnt_q <= cnt_q - 12'h001;
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         int_n_out <= 1'b1;
      else
         int_n_out <= ~(start_in | (cnt_q > 12'h001)); // [RL17]
   end

endmodule

// [tb/touch_report_checker.sv]
module touch_report_checker
(
   // clocks and reset
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic link_clk_in,
   // serial pins
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe_out,
   // report status
   input wire logic live_event_in,
   input wire logic int_n_out,
   input wire logic read_protect_out,
   input wire logic refresh_pending_out
);
   timeunit 1ns;
   timeprecision 100ps;

   // ==========================================================
   // length of the running interrupt pulse
   logic [15:0] low_cnt_q;

   always_ff @(posedge clk_in)
   begin
      if (rst_in || int_n_out)
         low_cnt_q <= 16'h0000;
      else
         low_cnt_q <= low_cnt_q + 16'h0001;
   end

   // ==========================================================
   // serial pins
   a_open_drain:
   assert property (@(posedge link_clk_in) disable iff (rst_in)
      sda_out == 1'b0) else $error("data pin driven high");
   a_sda_scl_low:
   assert property (@(posedge link_clk_in) disable iff (rst_in)
      $changed(sda_oe_out) |-> !scl_in)
      else $error("data pin moved while clock high");

   // ==========================================================
   // snapshot refresh and interrupt
   a_event_pending:
   assert property (@(posedge clk_in) disable iff (rst_in)
      live_event_in |=> refresh_pending_out)
      else $error("touch event not noted");
   // output lags the bus side by two cycles, so look back into the window
   a_hold_while_read:
   assert property (@(posedge clk_in) disable iff (rst_in)
      refresh_pending_out && read_protect_out ##1 read_protect_out [*6]
      |-> $past(refresh_pending_out, 4))
      else $error("copy refreshed during open read");
   a_stop_releases:
   assert property (@(posedge clk_in) disable iff (rst_in)
      $fell(read_protect_out) && refresh_pending_out
      |-> ##[0:4] !refresh_pending_out)
      else $error("refresh not released by stop");
   a_refresh_signals:
   assert property (@(posedge clk_in) disable iff (rst_in)
      $fell(refresh_pending_out) |-> ##[0:2] !int_n_out)
      else $error("refresh without interrupt");
   a_int_has_cause:
   assert property (@(posedge clk_in) disable iff (rst_in)
      $fell(int_n_out)
      |-> $past(refresh_pending_out) || $past(refresh_pending_out, 2))
      else $error("interrupt without pending refresh");
   a_int_min_width:
   assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(int_n_out) |-> low_cnt_q >= 16'h000A)
      else $error("interrupt pulse too short");

endmodule

// [tb/bus_host_model.sv]
module bus_host_model
(
   // wired data level
   input  wire logic sda_in,
   // host pins
   output logic      scl_out,
   output logic      sda_low_out
);
   timeunit 1ns;
   timeprecision 100ps;

   // 1250 gives 400 khz, 5000 gives 100 khz
   int half_ns = 1250;

   initial
   begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end

   // ==========================================================
   // framing; data moves only a quarter bit after clock falls
   task automatic start();
      #(half_ns / 2) sda_low_out = 1'b0;
      #(half_ns / 2) scl_out = 1'b1;
      #(half_ns) sda_low_out = 1'b1;
      #(half_ns) scl_out = 1'b0;
   endtask

   task automatic stop();
      #(half_ns / 2) sda_low_out = 1'b1;
      #(half_ns / 2) scl_out = 1'b1;
      #(half_ns) sda_low_out = 1'b0;
      #(half_ns);
   endtask

   task automatic bit_io(input logic b, output logic r);
      #(half_ns / 2) sda_low_out = ~b;
      #(half_ns / 2) scl_out = 1'b1;
      #(half_ns) r = sda_in;
      scl_out = 1'b0;
   endtask

   // ==========================================================
   // bytes, msb first
   task automatic wr_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask

   task automatic rd_byte(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(1'b1, r);
         b[i] = r;
      end
      bit_io(last, r);
   endtask

endmodule

// [tb/touch_report_i2c_slave_test.sv]
bind touch_report_i2c_slave touch_report_checker u_checker
(
   .clk_in              (clk_in),
   .rst_in              (rst_in),
   .link_clk_in         (link_clk_in),
   .scl_in              (scl_in),
   .sda_out             (sda_out),
   .sda_oe_out          (sda_oe_out),
   .live_event_in       (live_event_in),
   .int_n_out           (int_n_out),
   .read_protect_out    (read_protect_out),
   .refresh_pending_out (refresh_pending_out)
);

module touch_report_i2c_slave_test;
   timeunit 1ns;
   timeprecision 100ps;

   // ==========================================================
   // pins and bench state
   logic        clk_in        = 1'b0;
   logic        rst_in        = 1'b1;
   logic        link_clk_in   = 1'b0;
   logic        live_wr_in    = 1'b0;
   logic [4:0]  live_addr_in  = 5'h00;
   logic [7:0]  live_data_in  = 8'h00;
   logic        live_event_in = 1'b0;
   logic        scl_in;
   logic        sda_low;
   logic        sda_out;
   logic        sda_oe_out;
   logic        int_n_out;
   logic        read_protect_out;
   logic        refresh_pending_out;
   wire         sda_in;
   logic [7:0]  live_m [27];
   logic [7:0]  snap_m [27];
   logic [15:0] exp_q [$];
   logic [15:0] got_q [$];
   event        got_ev;
   logic [31:0] rng           = 32'h0b62_b43c;
   int          errors        = 0;
   int          n_tests       = 0;
   int          cyc           = 0;

   // pull-up on the data line
   assign sda_in = ~(sda_low | (sda_oe_out & ~sda_out));

   touch_report_i2c_slave u_touch_report_i2c_slave
   (
      .clk_in              (clk_in),
      .rst_in              (rst_in),
      .link_clk_in         (link_clk_in),
      .scl_in              (scl_in),
      .sda_in              (sda_in),
      .sda_out             (sda_out),
      .sda_oe_out          (sda_oe_out),
      .live_wr_in          (live_wr_in),
      .live_addr_in        (live_addr_in),
      .live_data_in        (live_data_in),
      .live_event_in       (live_event_in),
      .int_n_out           (int_n_out),
      .read_protect_out    (read_protect_out),
      .refresh_pending_out (refresh_pending_out)
   );

   bus_host_model host
   (
      .sda_in      (sda_in),
      .scl_out     (scl_in),
      .sda_low_out (sda_low)
   );

   always #50 clk_in = ~clk_in;

   initial
   begin
      #0.7;
      forever #3 link_clk_in = ~link_clk_in;
   end

   // ==========================================================
   // checking
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic expect_v(input logic [15:0] e, input logic [15:0] g);
      exp_q.push_back(e);
      got_q.push_back(g);
      -> got_ev;
   endtask

   // several results may land in one time step; drain them all
   always @(got_ev)
      while (got_q.size() > 0)
         check(got_q.pop_front(), exp_q.pop_front());

   task automatic final_report();
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   always @(posedge clk_in)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         errors++;
         final_report();
      end
   end

   // ==========================================================
   // drivers
   task automatic load_live();
      for (int a = 0; a < 27; a++)
      begin
         rng = xs(rng);
         live_m[a] = rng[7:0];
         @(negedge clk_in);
         live_wr_in = 1'b1;
         live_addr_in = a[4:0];
         live_data_in = rng[7:0];
      end
      @(negedge clk_in);
      live_wr_in = 1'b0;
   endtask

   task automatic pulse_event();
      @(negedge clk_in);
      live_event_in = 1'b1;
      @(negedge clk_in);
      live_event_in = 1'b0;
   endtask

   // waits for the pulse, then counts its low cycles
   task automatic int_width(input int w);
      int k;
      int n;
      k = 0;
      n = 0;
      while (int_n_out !== 1'b0 && k < 200)
      begin
         @(negedge clk_in);
         k++;
      end
      while (int_n_out === 1'b0 && n < 3000)
      begin
         @(negedge clk_in);
         n++;
      end
      expect_v(16'(w * 10), 16'(n));
   endtask

   task automatic send(input logic [7:0] b, input logic ack);
      logic a;
      host.wr_byte(b, a);
      expect_v({15'h0000, ack}, {15'h0000, a});
   endtask

   task automatic set_ptr(input logic [7:0] p);
      host.start();
      send(8'hB8, 1'b1);
      send(p, 1'b1);
      host.stop();
   endtask

   task automatic rd_bytes(input int p, input int n, input logic last);
      logic [7:0] b;
      logic [7:0] e;
      for (int i = 0; i < n; i++)
      begin
         host.rd_byte(last && i == n - 1, b);
         e = (p + i < 27) ? snap_m[p + i] : 8'h00;
         expect_v({8'h00, e}, {8'h00, b});
      end
   endtask

   task automatic rd(input int p, input int n);
      host.start();
      send(8'hB9, 1'b1);
      rd_bytes(p, n, 1'b1);
      host.stop();
   endtask

   // ==========================================================
   // scenarios
   initial
   begin
      repeat (10) @(negedge clk_in);
      rst_in = 1'b0;
      repeat (4) @(negedge clk_in);
      load_live();
      pulse_event();
      snap_m = live_m;
      int_width(10);
      set_ptr(8'h00);
      rd(0, 29);
      set_ptr(8'h05);
      rd(5, 1);
      rd(6, 1);
      // new frame arrives while a read is open
      host.start();
      send(8'hB8, 1'b1);
      send(8'h02, 1'b1);
      host.start();
      send(8'hB9, 1'b1);
      rd_bytes(2, 2, 1'b0);
      load_live();
      pulse_event();
      repeat (5) @(negedge clk_in);
      expect_v(16'h0001, {15'h0000, refresh_pending_out});
      expect_v(16'h0001, {15'h0000, int_n_out});
      expect_v(16'h0001, {15'h0000, read_protect_out});
      rd_bytes(4, 3, 1'b1);
      fork
         host.stop();
         int_width(10);
      join
      expect_v(16'h0000, {15'h0000, read_protect_out});
      snap_m = live_m;
      set_ptr(8'h02);
      rd(2, 5);
      // width set mid-write, last report byte acks but drops the write
      host.start();
      send(8'hB8, 1'b1);
      send(8'h1A, 1'b1);
      send(8'h55, 1'b1);
      send(8'h03, 1'b1);
      pulse_event();
      int_width(3);
      host.stop();
      set_ptr(8'h1A);
      rd(26, 2);
      for (int i = 0; i < 2; i++)
      begin
         host.start();
         send(8'hBA + 8'(i), 1'b0);
         host.stop();
      end
      host.half_ns = 5000;
      set_ptr(8'h00);
      rd(0, 3);
      final_report();
   end

endmodule
